// >>> hw/cpm_defs.svh
`ifndef CPM_DEFS_SVH
`define CPM_DEFS_SVH
// ----------------------------------------------------------------------------
// Register word indices (byte address = index * 4).
// ----------------------------------------------------------------------------
`define CPM_IDX_PLL        2'h0
`define CPM_IDX_REFERENCE_CLOCK_PIN     2'h1
`define CPM_IDX_OSC        2'h2
`define CPM_IDX_STATUS     2'h3
// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define CPM_REF_EN_BIT     15
`define CPM_REF_SLP_BIT    13
`define CPM_REF_SEL_BIT    12
`define CPM_REF_DIV_HI     11
`define CPM_REF_DIV_LO     8
`define CPM_OSC_NEW_HI     10
`define CPM_OSC_NEW_LO     8
// ----------------------------------------------------------------------------
// Reset values and constants.
// ----------------------------------------------------------------------------
`define CPM_PLL_RESET      9'h030
`define CPM_PLL_OFFSET     10'h002
`define CPM_OSC_RESET      3'h0
`define CPM_RESP_OKAY      2'h0
`define CPM_RESP_SLVERR    2'h2
`endif

// >>> hw/cpm_pkg.sv
`default_nettype none
package cpm_pkg;
	// Power state, Gray coded along run -> idle -> sleep.
	typedef enum logic [1:0] {
		CPM_RUN   = 2'b00,
		CPM_IDLE  = 2'b01,
		CPM_SLEEP = 2'b11
	} cpm_state_type;
	// Cause of the most recent wake-up.
	typedef enum logic [1:0] {
		CPM_WAKE_NONE = 2'b00,
		CPM_WAKE_IRQ  = 2'b01,
		CPM_WAKE_WDT  = 2'b10,
		CPM_WAKE_RST  = 2'b11
	} cpm_wake_type;
endpackage
`default_nettype wire

// >>> hw/cpm_reference_clock_pin_gen.sv
`default_nettype none
module cpm_reference_clock_pin_gen (
	input  wire logic aclk,
	input  wire logic aresetn,
	cpm_reference_clock_pin_if.gen rc
);
	// ------------------------------------------------------------------------
	// Source tick and run condition.
	// ------------------------------------------------------------------------
	logic        xtal_q;     // Previous crystal level, for edge detect.
	logic [14:0] count;      // Tick counter feeding the divider taps.
	logic [14:0] next_count; // Counter after one more tick.
	logic        running;    // Generator may toggle.
	logic        tick;       // One source period has passed.
	logic [3:0]  tap;        // Counter bit that drives the output.

	// Runs only while enabled, and in Sleep only when asked to.
	assign running    = rc.enable && !(rc.in_sleep && !rc.run_in_sleep);
	// Crystal source counts rising edges; system source counts every cycle.
	assign tick       = rc.source_sel ? (rc.xtal_in && !xtal_q) : 1'b1;
	assign next_count = count + 15'h0001;
	assign tap        = rc.divider - 4'h1;

	// Crystal edge detector; the input is already synchronous.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xtal_q <= 1'b0;
		end else begin
			xtal_q <= rc.xtal_in;
		end
	end

	// ------------------------------------------------------------------------
	// Divider counter.
	// ------------------------------------------------------------------------
	// The counter is not resynchronised on a divider change; software stops
	// the output first, which clears it.
	always_ff @(posedge aclk) begin
		if (!aresetn || !running) begin
			count <= 15'h0000;
		end else if (tick) begin
			count <= next_count;
		end
	end

	// Output follows the chosen counter bit: period is 2^divider ticks.
	always_ff @(posedge aclk) begin
		if (!aresetn || !running) begin
			rc.reference_clock_pin_out <= 1'b0;
		end else if (rc.divider == 4'h0) begin
			if (rc.source_sel) begin
				// The crystal is slower than aclk, so its level passes straight through.
				rc.reference_clock_pin_out <= rc.xtal_in;
			end else begin
				// A flop cannot pass aclk itself through, so this setting halves it.
				rc.reference_clock_pin_out <= !rc.reference_clock_pin_out;
			end
		end else if (tick) begin
			rc.reference_clock_pin_out <= next_count[tap];
		end
	end

	// ------------------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------------------
	a_reference_clock_pin_sleep_stop: assert property (@(posedge aclk) disable iff (!aresetn)
		(rc.in_sleep && !rc.run_in_sleep) |=> !rc.reference_clock_pin_out)
		else $error("Reference clock ran in Sleep without run-in-sleep.");
	a_reference_clock_pin_disabled_low: assert property (@(posedge aclk) disable iff (!aresetn)
		!rc.enable |=> !rc.reference_clock_pin_out)
		else $error("Reference clock toggled while disabled.");
	a_reference_clock_pin_sys_half: assert property (@(posedge aclk) disable iff (!aresetn)
		(running && !rc.source_sel && rc.divider == 4'h0) ##1
		(running && !rc.source_sel && rc.divider == 4'h0) |-> rc.reference_clock_pin_out != $past(rc.reference_clock_pin_out))
		else $error("Undivided system source failed to toggle.");
	a_reference_clock_pin_xtal_pass: assert property (@(posedge aclk) disable iff (!aresetn)
		(running && rc.source_sel && rc.divider == 4'h0) |=> rc.reference_clock_pin_out == $past(rc.xtal_in))
		else $error("Undivided crystal source not passed through.");
endmodule // cpm_reference_clock_pin_gen
`default_nettype wire

// >>> hw/cpm_reference_clock_pin_if.sv
`default_nettype none
// Settings and status passed between the controller and the reference clock generator.
interface cpm_reference_clock_pin_if;
	logic       enable;       // Output enable.
	logic       run_in_sleep; // Keep running while asleep.
	logic       source_sel;   // 1 = crystal, 0 = system clock.
	logic [3:0] divider;      // Power-of-two divider.
	logic       in_sleep;     // Device is in Sleep.
	logic       xtal_in;      // Sampled crystal oscillator level.
	logic       reference_clock_pin_out;   // Generated reference clock.
	modport ctrl (output enable, run_in_sleep, source_sel, divider, in_sleep, xtal_in, input reference_clock_pin_out);
	modport gen  (input enable, run_in_sleep, source_sel, divider, in_sleep, xtal_in, output reference_clock_pin_out);
endinterface
`default_nettype wire

// >>> hw/cpm_top.sv
// Function
// - Sleep instruction stops core and peripheral clocks and execution.
// - Idle instruction halts core, peripherals stay clocked.
// - Only the instruction enters Sleep or Idle.
// - Interrupt, watchdog or reset wakes the device.
// - Unlocked oscillator select write requests clock switch.
// - Multiplier is field plus two, resets 50.
// - Run-in-sleep bit keeps reference clock alive.
`default_nettype none
`include "cpm_defs.svh"
module cpm_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        power_save_instruction,
	input  wire logic        power_save_idle,
	input  wire logic        enabled_irq_req,
	input  wire logic        watchdog_timeout,
	input  wire logic        device_reset_event,
	input  wire logic        clock_config_locked,
	input  wire logic        xtal_osc_in,
	output var  logic        core_clk_enable,
	output var  logic        periph_clk_enable,
	output var  logic        osc_switch_req,
	output var  logic [2:0]  osc_switch_target,
	output var  logic [9:0]  pll_multiplier,
	output var  logic        reference_clock_pin
);
	// ------------------------------------------------------------------------
	// Register state.
	// ------------------------------------------------------------------------
	logic [8:0]            feedback_multiplier_field; // PLL feedback field.
	logic                  reference_clock_pin_output_enable;      // Reference clock on.
	logic                  reference_clock_pin_run_in_sleep;       // Keep running in Sleep.
	logic                  reference_clock_pin_source_select;      // 1 = crystal.
	logic [3:0]            reference_clock_pin_divider;            // Power-of-two divider.
	logic [2:0]            new_oscillator_select;     // Requested oscillator.
	cpm_pkg::cpm_state_type state;                    // Power state.
	cpm_pkg::cpm_state_type next_state;               // Power state next cycle.
	cpm_pkg::cpm_wake_type  wake_cause;               // Last wake-up cause.
	logic                  wake_event;                // Any wake source active.

	// ------------------------------------------------------------------------
	// AXI4-Lite write channel capture.
	// ------------------------------------------------------------------------
	logic        aw_full;      // Write address held.
	logic        w_full;       // Write data held.
	logic [1:0]  aw_idx;       // Held register index.
	logic        aw_bad;       // Held address is unmapped.
	logic [15:0] w_data;       // Held write data, low half only.
	logic [1:0]  w_strb;       // Held byte strobes of the low half.
	logic        wr_do;        // Write performed this cycle.
	logic        next_aw_full; // Address holder next cycle.
	logic        next_w_full;  // Data holder next cycle.
	logic        osc_wr_fire;  // Accepted oscillator switch write.

	// Address and data may come in either order; the write runs once both
	// are held and the previous response has been taken.
	assign wr_do        = aw_full && w_full && !s_axi_bvalid;
	assign next_aw_full = (aw_full && !wr_do) || (s_axi_awvalid && s_axi_awready);
	assign next_w_full  = (w_full && !wr_do) || (s_axi_wvalid && s_axi_wready);
	// Only an unlocked write with the select byte strobed asks for a switch.
	assign osc_wr_fire  = wr_do && !aw_bad && aw_idx == `CPM_IDX_OSC && w_strb[1] && !clock_config_locked;

	// Address holder and its ready, registered from the next fill state.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full       <= 1'b0;
			s_axi_awready <= 1'b0;
			aw_idx        <= 2'h0;
			aw_bad        <= 1'b0;
		end else begin
			aw_full       <= next_aw_full;
			s_axi_awready <= !next_aw_full;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_idx <= s_axi_awaddr[3:2];
				aw_bad <= s_axi_awaddr[31:4] != 28'h0000000;
			end
		end
	end

	// Data holder and its ready; upper half is ignored as registers are 16 bits.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full       <= 1'b0;
			s_axi_wready <= 1'b0;
			w_data       <= 16'h0000;
			w_strb       <= 2'h0;
		end else begin
			w_full       <= next_w_full;
			s_axi_wready <= !next_w_full;
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata[15:0];
				w_strb <= s_axi_wstrb[1:0];
			end
		end
	end

	// Write response: an unmapped address answers SLVERR and changes nothing.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `CPM_RESP_OKAY;
		end else if (wr_do) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= aw_bad ? `CPM_RESP_SLVERR : `CPM_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Software registers.
	// ------------------------------------------------------------------------
	// PLL feedback field, byte-lane writable, resets to a multiplier of 50.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			feedback_multiplier_field <= `CPM_PLL_RESET;
		end else if (wr_do && !aw_bad && aw_idx == `CPM_IDX_PLL) begin
			if (w_strb[0]) begin
				feedback_multiplier_field[7:0] <= w_data[7:0];
			end
			if (w_strb[1]) begin
				feedback_multiplier_field[8] <= w_data[8];
			end
		end
	end

	// Reference clock control; all fields live in the upper byte.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reference_clock_pin_output_enable <= 1'b0;
			reference_clock_pin_run_in_sleep  <= 1'b0;
			reference_clock_pin_source_select <= 1'b0;
			reference_clock_pin_divider       <= 4'h0;
		end else if (wr_do && !aw_bad && aw_idx == `CPM_IDX_REFERENCE_CLOCK_PIN && w_strb[1]) begin
			reference_clock_pin_output_enable <= w_data[`CPM_REF_EN_BIT];
			reference_clock_pin_run_in_sleep  <= w_data[`CPM_REF_SLP_BIT];
			reference_clock_pin_source_select <= w_data[`CPM_REF_SEL_BIT];
			reference_clock_pin_divider       <= w_data[`CPM_REF_DIV_HI:`CPM_REF_DIV_LO];
		end
	end

	// Oscillator select; a locked configuration ignores the write.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			new_oscillator_select <= `CPM_OSC_RESET;
			osc_switch_req        <= 1'b0;
			osc_switch_target     <= `CPM_OSC_RESET;
		end else begin
			osc_switch_req <= osc_wr_fire;
			if (osc_wr_fire) begin
				new_oscillator_select <= w_data[`CPM_OSC_NEW_HI:`CPM_OSC_NEW_LO];
				osc_switch_target     <= w_data[`CPM_OSC_NEW_HI:`CPM_OSC_NEW_LO];
			end
		end
	end

	// Multiplier presented to the PLL is the field plus two.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pll_multiplier <= {1'b0, `CPM_PLL_RESET} + `CPM_PLL_OFFSET;
		end else begin
			pll_multiplier <= {1'b0, feedback_multiplier_field} + `CPM_PLL_OFFSET;
		end
	end

	// ------------------------------------------------------------------------
	// AXI4-Lite read channel.
	// ------------------------------------------------------------------------
	// One read at a time; unmapped addresses read zero with SLVERR.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `CPM_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid  <= 1'b1;
			s_axi_arready <= 1'b0;
			s_axi_rresp   <= `CPM_RESP_OKAY;
			s_axi_rdata   <= 32'h00000000;
			if (s_axi_araddr[31:4] != 28'h0000000) begin
				s_axi_rresp <= `CPM_RESP_SLVERR;
			end else begin
				unique case (s_axi_araddr[3:2])
					`CPM_IDX_PLL: begin
						s_axi_rdata[8:0] <= feedback_multiplier_field;
					end
					`CPM_IDX_REFERENCE_CLOCK_PIN: begin
						s_axi_rdata[`CPM_REF_EN_BIT]                 <= reference_clock_pin_output_enable;
						s_axi_rdata[`CPM_REF_SLP_BIT]                <= reference_clock_pin_run_in_sleep;
						s_axi_rdata[`CPM_REF_SEL_BIT]                <= reference_clock_pin_source_select;
						s_axi_rdata[`CPM_REF_DIV_HI:`CPM_REF_DIV_LO] <= reference_clock_pin_divider;
					end
					`CPM_IDX_OSC: begin
						s_axi_rdata[`CPM_OSC_NEW_HI:`CPM_OSC_NEW_LO] <= new_oscillator_select;
						s_axi_rdata[0]                               <= clock_config_locked;
					end
					`CPM_IDX_STATUS: begin
						s_axi_rdata[1:0] <= state;
						s_axi_rdata[5:4] <= wake_cause;
					end
				endcase
			end
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	// ------------------------------------------------------------------------
	// Power state machine.
	// ------------------------------------------------------------------------
	assign wake_event = enabled_irq_req || watchdog_timeout || device_reset_event;

	// Entry only through the instruction; no register bit can put the device to sleep.
	always_comb begin
		next_state = state;
		unique case (state)
			cpm_pkg::CPM_RUN: begin
				if (power_save_instruction) begin
					next_state = power_save_idle ? cpm_pkg::CPM_IDLE : cpm_pkg::CPM_SLEEP;
				end
			end
			cpm_pkg::CPM_IDLE, cpm_pkg::CPM_SLEEP: begin
				if (wake_event) begin
					next_state = cpm_pkg::CPM_RUN;
				end
			end
			default: begin
				next_state = cpm_pkg::CPM_RUN;
			end
		endcase
	end

	// State and clock gates move together so the gates never lag the state.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state             <= cpm_pkg::CPM_RUN;
			core_clk_enable   <= 1'b1;
			periph_clk_enable <= 1'b1;
		end else begin
			state             <= next_state;
			core_clk_enable   <= next_state == cpm_pkg::CPM_RUN;
			periph_clk_enable <= next_state != cpm_pkg::CPM_SLEEP;
		end
	end

	// Wake cause, priority reset over watchdog over interrupt.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wake_cause <= cpm_pkg::CPM_WAKE_NONE;
		end else if (state != cpm_pkg::CPM_RUN && wake_event) begin
			if (device_reset_event) begin
				wake_cause <= cpm_pkg::CPM_WAKE_RST;
			end else if (watchdog_timeout) begin
				wake_cause <= cpm_pkg::CPM_WAKE_WDT;
			end else begin
				wake_cause <= cpm_pkg::CPM_WAKE_IRQ;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Reference clock generator.
	// ------------------------------------------------------------------------
	cpm_reference_clock_pin_if reference_clock_pin_bus ();
	assign reference_clock_pin_bus.enable       = reference_clock_pin_output_enable;
	assign reference_clock_pin_bus.run_in_sleep = reference_clock_pin_run_in_sleep;
	assign reference_clock_pin_bus.source_sel   = reference_clock_pin_source_select;
	assign reference_clock_pin_bus.divider      = reference_clock_pin_divider;
	assign reference_clock_pin_bus.in_sleep     = state == cpm_pkg::CPM_SLEEP;
	assign reference_clock_pin_bus.xtal_in      = xtal_osc_in;

	cpm_reference_clock_pin_gen u_reference_clock_pin_gen (
		.aclk    (aclk),
		.aresetn (aresetn),
		.rc      (reference_clock_pin_bus)
	);

	// Retimed to the pin so the top output comes from a flop.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reference_clock_pin <= 1'b0;
		end else begin
			reference_clock_pin <= reference_clock_pin_bus.reference_clock_pin_out;
		end
	end

	// ------------------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------------------
	a_sleep_clocks_off: assert property (@(posedge aclk) disable iff (!aresetn)
		(state == cpm_pkg::CPM_SLEEP) |-> (!core_clk_enable && !periph_clk_enable))
		else $error("Clocks running in Sleep.");
	a_idle_periph_on: assert property (@(posedge aclk) disable iff (!aresetn)
		(state == cpm_pkg::CPM_IDLE) |-> (!core_clk_enable && periph_clk_enable))
		else $error("Idle gating wrong.");
	a_entry_by_instr: assert property (@(posedge aclk) disable iff (!aresetn)
		(state == cpm_pkg::CPM_RUN && !power_save_instruction) |=> state == cpm_pkg::CPM_RUN)
		else $error("Power save entered without the instruction.");
	a_instr_enters: assert property (@(posedge aclk) disable iff (!aresetn)
		(state == cpm_pkg::CPM_RUN && power_save_instruction && !power_save_idle) |=> state == cpm_pkg::CPM_SLEEP)
		else $error("Sleep instruction did not enter Sleep.");
	a_wake_event_run: assert property (@(posedge aclk) disable iff (!aresetn)
		(state != cpm_pkg::CPM_RUN && wake_event) |=> (state == cpm_pkg::CPM_RUN && core_clk_enable))
		else $error("Wake event did not wake the device.");
	a_osc_switch_req: assert property (@(posedge aclk) disable iff (!aresetn)
		osc_wr_fire |=> (osc_switch_req && osc_switch_target == $past(w_data[`CPM_OSC_NEW_HI:`CPM_OSC_NEW_LO])))
		else $error("Oscillator switch not requested.");
	a_osc_locked_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
		clock_config_locked |=> !osc_switch_req)
		else $error("Switch requested while locked.");
	a_pll_mult_plus2: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 pll_multiplier == {1'b0, $past(feedback_multiplier_field)} + 10'h002)
		else $error("Multiplier is not field plus two.");
endmodule // cpm_top
`default_nettype wire

// >>> verif/cpm_top_bench.sv
`default_nettype none
`include "cpm_defs.svh"
// Compares one value against its expectation and counts both the check and any mismatch.
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
	$display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module cpm_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	// ------------------------------------------------------------------
	// Stimulus and observed signals.
	// ------------------------------------------------------------------
	logic        aclk = 1'b0;        // System clock, 25 MHz.
	logic        aresetn = 1'b0;     // Synchronous reset, active low.
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
	logic        awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
	logic        arvalid = 0, arready, rvalid, rready = 0;
	logic [1:0]  bresp, rresp;
	logic        instr = 0, psidle = 0, irq = 0, wdt = 0, rst_ev = 0, locked = 0;
	logic        xtal = 1'b0;        // Crystal stand-in, rises every fourth cycle.
	logic [1:0]  xcnt = '0;
	logic        core_en, periph_en, sw_req, pin, pin_q = 1'b0;
	logic [2:0]  sw_target;
	logic [9:0]  mult;
	int          num_errors = 0, num_checks = 0, rises = 0, pulses = 0;
	// The clock toggles every half period of 20 ns.
	always #20 aclk = ~aclk;
	// Crystal, pin-edge and switch-pulse monitors; counters only grow, so tests take differences.
	always @(posedge aclk) begin
		xcnt <= xcnt + 2'h1;
		xtal <= xcnt[1];
		pin_q <= pin;
		if (pin && !pin_q) rises <= rises + 1;
		if (sw_req) pulses <= pulses + 1;
	end
	cpm_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.power_save_instruction(instr), .power_save_idle(psidle), .enabled_irq_req(irq),
		.watchdog_timeout(wdt), .device_reset_event(rst_ev), .clock_config_locked(locked),
		.xtal_osc_in(xtal), .core_clk_enable(core_en), .periph_clk_enable(periph_en),
		.osc_switch_req(sw_req), .osc_switch_target(sw_target), .pll_multiplier(mult),
		.reference_clock_pin(pin));
	// ------------------------------------------------------------------
	// Closing report and bus tasks.
	// ------------------------------------------------------------------
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Address and data are offered together; each is dropped at the edge that takes it.
	task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
		int n;
		@(posedge aclk);
		awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (bvalid) break;
		end
		resp = bresp;
		bready <= 0;
		if (n == 200) begin num_errors++; stop_test(); end
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
		int n;
		@(posedge aclk);
		araddr <= a; arvalid <= 1; rready <= 1;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 0;
			if (rvalid) break;
		end
		d = rdata; resp = rresp;
		rready <= 0;
		if (n == 200) begin num_errors++; stop_test(); end
	endtask
	// Enters a power-save state; the later edges let the registered enables settle.
	task automatic enter(input logic idle);
		@(posedge aclk) begin instr <= 1; psidle <= idle; end
		@(posedge aclk) instr <= 0;
		repeat (3) @(posedge aclk);
	endtask
	// Raises one wake source for a single cycle: 0 interrupt, 1 watchdog, 2 device reset.
	task automatic wake(input int src);
		@(posedge aclk) begin irq <= (src == 0); wdt <= (src == 1); rst_ev <= (src == 2); end
		@(posedge aclk) begin irq <= 0; wdt <= 0; rst_ev <= 0; end
		repeat (3) @(posedge aclk);
	endtask
	// Counts pin rising edges over a window.
	task automatic measure(input int n, output int c);
		int r0;
		r0 = rises;
		repeat (n) @(posedge aclk);
		c = rises - r0;
	endtask
	// ------------------------------------------------------------------
	// Scenarios.
	// ------------------------------------------------------------------
	task automatic test_regs;
		logic [31:0] d;
		logic [1:0]  r;
		`CHK("reset multiplier", 10'd50, mult)
		rd(32'h0, d, r);
		`CHK("reset pll field", 32'h30, d)
		`CHK("read resp", `CPM_RESP_OKAY, r)
		wr(32'h0, 32'hffff01ff, r);
		`CHK("write resp", `CPM_RESP_OKAY, r)
		rd(32'h0, d, r);
		`CHK("pll field max", 32'h1ff, d)
		`CHK("multiplier max", 10'd513, mult)
		wr(32'h0, 32'h0, r);
		repeat (2) @(posedge aclk);
		`CHK("multiplier min", 10'd2, mult)
		wr(32'h10, 32'h1, r);
		`CHK("unmapped write resp", `CPM_RESP_SLVERR, r)
		rd(32'h10, d, r);
		`CHK("unmapped read resp", `CPM_RESP_SLVERR, r)
		`CHK("unmapped read data", 32'h0, d)
		$display("test_regs done");
	endtask
	task automatic test_osc;
		logic [31:0] d;
		logic [1:0] r;
		int p0;
		p0 = pulses;
		wr(32'h8, 32'h500, r);
		repeat (3) @(posedge aclk);
		`CHK("switch pulses", p0 + 1, pulses)
		`CHK("switch target", 3'h5, sw_target)
		@(posedge aclk) locked <= 1;
		wr(32'h8, 32'h300, r);
		repeat (3) @(posedge aclk);
		`CHK("locked pulses", p0 + 1, pulses)
		`CHK("locked target", 3'h5, sw_target)
		rd(32'h8, d, r);
		`CHK("locked select", 32'h501, d)
		@(posedge aclk) locked <= 0;
		$display("test_osc done");
	endtask
	task automatic test_power;
		logic [31:0] d;
		logic [1:0]  r;
		wr(32'hc, 32'h3, r);
		repeat (3) @(posedge aclk);
		`CHK("no register entry", 1'b1, core_en)
		for (int s = 0; s < 3; s++) begin
			enter(s[0]);
			`CHK("core stopped", 1'b0, core_en)
			`CHK("periph clock", s[0], periph_en)
			wake(s);
			`CHK("core woken", 1'b1, core_en)
			`CHK("periph woken", 1'b1, periph_en)
			rd(32'hc, d, r);
			`CHK("wake cause", 2'(s + 1), d[5:4])
		end
		$display("test_power done");
	endtask
	// Clears the enable before each new divider value, as software must.
	task automatic set_ref(input logic [31:0] v);
		logic [1:0] r;
		wr(32'h4, 32'h0, r);
		wr(32'h4, v, r);
		repeat (4) @(posedge aclk);
	endtask
	task automatic test_reference_clock_pin;
		logic [31:0] d;
		logic [1:0]  r;
		int          c;
		set_ref(32'h0000);
		measure(32, c);
		`CHK("disabled pin", 0, c)
		set_ref(32'h8000);
		rd(32'h4, d, r);
		`CHK("reference_clock_pin readback", 32'h8000, d)
		measure(64, c);
		`CHK("sys div0", 1'b1, c >= 31 && c <= 33)
		set_ref(32'h8300);
		measure(64, c);
		`CHK("sys div3", 1'b1, c >= 7 && c <= 9)
		set_ref(32'h9000);
		measure(64, c);
		`CHK("xtal div0", 1'b1, c >= 15 && c <= 17)
		set_ref(32'h9100);
		measure(64, c);
		`CHK("xtal div1", 1'b1, c >= 7 && c <= 9)
		set_ref(32'h8000);
		enter(1'b0);
		measure(32, c);
		`CHK("sleep stops pin", 0, c)
		wake(0);
		set_ref(32'ha000);
		enter(1'b0);
		measure(32, c);
		`CHK("sleep keeps pin", 1'b1, c >= 15 && c <= 17)
		wake(1);
		$display("test_reference_clock_pin done");
	endtask
	// ------------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------------
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		test_regs();
		test_osc();
		test_power();
		test_reference_clock_pin();
		stop_test();
	end
endmodule // cpm_top_bench
`default_nettype wire
